// >>> logic/bcr_pkg.sv
package bcr_pkg;

   // ****************************************************************
   // register indices; byte address is four times the index
   // ****************************************************************
   localparam logic [7:0] IDX_BUCK0_LIMIT_SLEW_CFG = 8'h03;
   localparam logic [7:0] IDX_BUCK1_MODE_ENABLE_CTRL = 8'h04;
   localparam logic [7:0] IDX_BUCK1_LIMIT_SLEW_CFG = 8'h05;
   localparam logic [7:0] IDX_BUCK0_OUTPUT_VOLTAGE = 8'h06;
   localparam int unsigned BYTE_SHIFT = 2;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int unsigned LIMIT_LSB = 3;
   localparam int unsigned RAMP_LSB = 0;
   localparam int unsigned FIELD_W = 3;
   localparam int unsigned FIXED_FREQ_BIT = 3;
   localparam int unsigned DISCHARGE_BIT = 2;
   localparam int unsigned PIN_GATING_BIT = 1;
   localparam int unsigned ON_BIT = 0;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_LIMIT_SLEW = 8'h2C;
   localparam logic [7:0] RST_MODE_ENABLE = 8'h0F;
   localparam logic [7:0] RST_VOLTAGE = 8'h80;

   // ****************************************************************
   // legal code ranges and voltage map
   // ****************************************************************
   localparam logic [2:0] LIMIT_CODE_MAX = 3'h5;
   localparam logic [2:0] RAMP_CODE_MIN = 3'h2;
   localparam logic [7:0] VCODE_MIN = 8'h14;
   localparam logic [7:0] VCODE_MID = 8'h18;
   localparam logic [7:0] VCODE_HIGH = 8'h9E;
   localparam logic [11:0] MV_LOW_BASE = 12'h2BC;
   localparam logic [11:0] MV_MID_BASE = 12'h2DF;
   localparam logic [11:0] MV_HIGH_BASE = 12'h58C;
   localparam logic [11:0] MV_LOW_STEP = 12'h00A;
   localparam logic [11:0] MV_MID_STEP = 12'h005;
   localparam logic [11:0] MV_HIGH_STEP = 12'h014;

   // ****************************************************************
   // bus answers
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed
   {
      logic [2:0] current_limit;
      logic [2:0] ramp_rate;
   } bcr_stage_t;

   typedef struct packed
   {
      bcr_stage_t stage;
      logic force_fixed_freq;
      logic discharge_on;
      logic running;
   } bcr_reg1_t;

   typedef struct packed
   {
      bcr_stage_t stage;
      logic [7:0] voltage_code;
      logic [11:0] voltage_mv;
   } bcr_reg0_t;

endpackage

// >>> logic/bcr_regs.sv
`timescale 1ns/100ps
// Functional notes
// - regulator 0 limit codes 0-5, 1.5-4.0 A
// - limit changes apply live, no disable needed
// - regulator 1 limit uses same encoding
// - regulator 0 ramp codes 2-7, both directions
// - regulator 1 ramp uses same table
// - mode bit: 0 auto, 1 forced fixed frequency
// - discharge resistor only while regulator 1 off
// - pin gating adds external enable pin
// - on bit enables or disables regulator 1
// - voltage codes below 0x14 are reserved
// - codes 0x14-0x17: 0.70-0.73 V, 10 mV
// - codes 0x18-0x9D: 0.735-1.4 V, 5 mV
// - codes 0x9E-0xFF: 1.42-3.36 V, 20 mV
module bcr_regs
   import bcr_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external enable pin, asynchronous
   input wire logic ext_enable_pin,
   // power stage controls
   output bcr_pkg::bcr_reg0_t reg0_ctrl,
   output bcr_pkg::bcr_reg1_t reg1_ctrl
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   if (ADDR_W < 5)
   begin : g_addr_check
      $error("bcr_regs: ADDR_W must be at least 5");
   end

   // ****************************************************************
   // functions
   // ****************************************************************
   // reserved codes are dropped so the analog stage sees them only while the controls hold reset zeros
   function automatic logic [7:0] merge_limit_slew(input logic [7:0] old_v,
                                                   input logic [7:0] wr_v);
      logic [7:0] res;
      res = old_v;
      if (wr_v[LIMIT_LSB +: FIELD_W] <= LIMIT_CODE_MAX)
      begin
         res[LIMIT_LSB +: FIELD_W] = wr_v[LIMIT_LSB +: FIELD_W];
      end
      if (wr_v[RAMP_LSB +: FIELD_W] >= RAMP_CODE_MIN)
      begin
         res[RAMP_LSB +: FIELD_W] = wr_v[RAMP_LSB +: FIELD_W];
      end
      res[7:6] = 2'h0;
      return res;
   endfunction

   function automatic logic [11:0] code_to_mv(input logic [7:0] code);
      logic [11:0] c;
      c = {4'h0, code};
      if (code >= VCODE_HIGH)
      begin
         return MV_HIGH_BASE + 12'((c - {4'h0, VCODE_HIGH}) * MV_HIGH_STEP);
      end
      else if (code >= VCODE_MID)
      begin
         return MV_MID_BASE + 12'((c - {4'h0, VCODE_MID}) * MV_MID_STEP);
      end
      else if (code >= VCODE_MIN)
      begin
         return MV_LOW_BASE + 12'((c - {4'h0, VCODE_MIN}) * MV_LOW_STEP);
      end
      return 12'h000;
   endfunction

   function automatic logic [7:0] addr_index(input logic [ADDR_W-1:0] a);
      return 8'(a >> BYTE_SHIFT);
   endfunction

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = addr_index(a);
      // the full index is compared so that a wide bus cannot alias the map
      return (a[1:0] == 2'h0) && ((a >> BYTE_SHIFT) == ADDR_W'(i))
             && (i >= IDX_BUCK0_LIMIT_SLEW_CFG) && (i <= IDX_BUCK0_OUTPUT_VOLTAGE);
   endfunction

   // ****************************************************************
   // enable pin synchroniser
   // ****************************************************************
   logic [2:0] pin_sync;
   logic pin_level;
   logic [2:0] next_pin_sync;
   logic next_pin_level;

   always_comb
   begin
      next_pin_sync = {pin_sync[1:0], ext_enable_pin};
      next_pin_level = pin_level;
      if (pin_sync[1] == pin_sync[2])
      begin
         next_pin_level = pin_sync[2];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         pin_sync <= 3'h0;
         pin_level <= 1'b0;
      end
      else
      begin
         pin_sync <= next_pin_sync;
         pin_level <= next_pin_level;
      end
   end

   // ****************************************************************
   // register file and bus slave
   // ****************************************************************
   logic [7:0] buck0_limit_slew_cfg;
   logic [7:0] buck1_mode_enable_ctrl;
   logic [7:0] buck1_limit_slew_cfg;
   logic [7:0] buck0_output_voltage;
   logic [7:0] next_buck0_limit_slew_cfg;
   logic [7:0] next_buck1_mode_enable_ctrl;
   logic [7:0] next_buck1_limit_slew_cfg;
   logic [7:0] next_buck0_output_voltage;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [1:0] next_rresp;
   logic [31:0] next_rdata;
   logic wr_go;
   logic rd_go;
   logic [7:0] rd_byte;

   // both write channels are taken in the same cycle; a lone one waits
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

   always_comb
   begin
      next_buck0_limit_slew_cfg = buck0_limit_slew_cfg;
      next_buck1_mode_enable_ctrl = buck1_mode_enable_ctrl;
      next_buck1_limit_slew_cfg = buck1_limit_slew_cfg;
      next_buck0_output_voltage = buck0_output_voltage;
      next_awready = wr_go;
      next_wready = wr_go;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_arready = rd_go;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      rd_byte = 8'h00;
      if (wr_go)
      begin
         next_bvalid = 1'b1;
         next_bresp = addr_hit(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (addr_hit(s_axi_awaddr) && s_axi_wstrb[0])
         begin
            // limit fields take effect on the next edge, running or not
            case (addr_index(s_axi_awaddr))
               IDX_BUCK0_LIMIT_SLEW_CFG:
               begin
                  next_buck0_limit_slew_cfg = merge_limit_slew(buck0_limit_slew_cfg,
                                                               s_axi_wdata[7:0]);
               end
               IDX_BUCK1_LIMIT_SLEW_CFG:
               begin
                  next_buck1_limit_slew_cfg = merge_limit_slew(buck1_limit_slew_cfg,
                                                               s_axi_wdata[7:0]);
               end
               IDX_BUCK1_MODE_ENABLE_CTRL:
               begin
                  next_buck1_mode_enable_ctrl = {4'h0, s_axi_wdata[3:0]};
               end
               IDX_BUCK0_OUTPUT_VOLTAGE:
               begin
                  if (s_axi_wdata[7:0] >= VCODE_MIN)
                  begin
                     next_buck0_output_voltage = s_axi_wdata[7:0];
                  end
               end
               default:
               begin
                  next_bresp = RESP_SLVERR;
               end
            endcase
         end
      end
      if (rd_go)
      begin
         case (addr_index(s_axi_araddr))
            IDX_BUCK0_LIMIT_SLEW_CFG: rd_byte = buck0_limit_slew_cfg;
            IDX_BUCK1_MODE_ENABLE_CTRL: rd_byte = buck1_mode_enable_ctrl;
            IDX_BUCK1_LIMIT_SLEW_CFG: rd_byte = buck1_limit_slew_cfg;
            IDX_BUCK0_OUTPUT_VOLTAGE: rd_byte = buck0_output_voltage;
            default: rd_byte = 8'h00;
         endcase
         next_rvalid = 1'b1;
         next_rresp = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         next_rdata = addr_hit(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         buck0_limit_slew_cfg <= RST_LIMIT_SLEW;
         buck1_mode_enable_ctrl <= RST_MODE_ENABLE;
         buck1_limit_slew_cfg <= RST_LIMIT_SLEW;
         buck0_output_voltage <= RST_VOLTAGE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end
      else
      begin
         buck0_limit_slew_cfg <= next_buck0_limit_slew_cfg;
         buck1_mode_enable_ctrl <= next_buck1_mode_enable_ctrl;
         buck1_limit_slew_cfg <= next_buck1_limit_slew_cfg;
         buck0_output_voltage <= next_buck0_output_voltage;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // power stage controls
   // ****************************************************************
   bcr_reg0_t next_reg0_ctrl;
   bcr_reg1_t next_reg1_ctrl;
   logic run1;

   always_comb
   begin
      // pin gating ands the synchronised pin into the on bit
      run1 = buck1_mode_enable_ctrl[ON_BIT]
             && (!buck1_mode_enable_ctrl[PIN_GATING_BIT] || pin_level);
      next_reg1_ctrl.running = run1;
      next_reg1_ctrl.force_fixed_freq = buck1_mode_enable_ctrl[FIXED_FREQ_BIT];
      next_reg1_ctrl.discharge_on = buck1_mode_enable_ctrl[DISCHARGE_BIT] && !run1;
      next_reg1_ctrl.stage.current_limit = buck1_limit_slew_cfg[LIMIT_LSB +: FIELD_W];
      next_reg1_ctrl.stage.ramp_rate = buck1_limit_slew_cfg[RAMP_LSB +: FIELD_W];
      next_reg0_ctrl.stage.current_limit = buck0_limit_slew_cfg[LIMIT_LSB +: FIELD_W];
      next_reg0_ctrl.stage.ramp_rate = buck0_limit_slew_cfg[RAMP_LSB +: FIELD_W];
      next_reg0_ctrl.voltage_code = buck0_output_voltage;
      next_reg0_ctrl.voltage_mv = code_to_mv(buck0_output_voltage);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         reg0_ctrl <= '0;
         reg1_ctrl <= '0;
      end
      else
      begin
         reg0_ctrl <= next_reg0_ctrl;
         reg1_ctrl <= next_reg1_ctrl;
      end
   end

endmodule

// >>> dv/bcr_regs_props.sv
`timescale 1ns/100ps
// ****************
// stage control checks
// ****************
module bcr_regs_chk
   import bcr_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // write side of the bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   // stage controls
   input wire bcr_pkg::bcr_reg0_t reg0_ctrl,
   input wire bcr_pkg::bcr_reg1_t reg1_ctrl
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // outputs still hold reset zeros one edge after release, hence the $past guards
   property p_dis; $past(rst_b) |-> !(reg1_ctrl.discharge_on && reg1_ctrl.running); endproperty
   a_dis: assert property (p_dis) else $error("discharge while stage 1 runs");
   property p_lim0; $past(rst_b) |-> reg0_ctrl.stage.current_limit <= 3'h5; endproperty
   a_lim0: assert property (p_lim0) else $error("stage 0 limit code reserved");
   property p_lim1; $past(rst_b) |-> reg1_ctrl.stage.current_limit <= 3'h5; endproperty
   a_lim1: assert property (p_lim1) else $error("stage 1 limit code reserved");
   property p_rmp0; $past(rst_b) |-> reg0_ctrl.stage.ramp_rate >= 3'h2; endproperty
   a_rmp0: assert property (p_rmp0) else $error("stage 0 ramp code reserved");
   property p_rmp1; $past(rst_b) |-> reg1_ctrl.stage.ramp_rate >= 3'h2; endproperty
   a_rmp1: assert property (p_rmp1) else $error("stage 1 ramp code reserved");
   property p_vres; $past(rst_b) |-> reg0_ctrl.voltage_code >= 8'h14; endproperty
   a_vres: assert property (p_vres) else $error("voltage code reserved");
   property p_vlow; reg0_ctrl.voltage_code inside {[8'h14:8'h17]}
      |-> reg0_ctrl.voltage_mv == 700 + 10 * (reg0_ctrl.voltage_code - 8'h14); endproperty
   a_vlow: assert property (p_vlow) else $error("low band voltage wrong");
   property p_vmid; reg0_ctrl.voltage_code inside {[8'h18:8'h9D]}
      |-> reg0_ctrl.voltage_mv == 735 + 5 * (reg0_ctrl.voltage_code - 8'h18); endproperty
   a_vmid: assert property (p_vmid) else $error("mid band voltage wrong");
   property p_vhigh; $past(rst_b) && reg0_ctrl.voltage_code >= 8'h9E
      |-> reg0_ctrl.voltage_mv == 1420 + 20 * (reg0_ctrl.voltage_code - 8'h9E); endproperty
   a_vhigh: assert property (p_vhigh) else $error("high band voltage wrong");
   property p_off; s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      && s_axi_awaddr == 'h10 && s_axi_wstrb[0] && !s_axi_wdata[0]
      |-> ##[1:3] !reg1_ctrl.running; endproperty
   a_off: assert property (p_off) else $error("stage 1 still runs after off");
endmodule
bind bcr_regs bcr_regs_chk #(.ADDR_W(ADDR_W)) bcr_regs_chk_inst (.clock, .rst_b, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid,
   .reg0_ctrl, .reg1_ctrl);

// >>> dv/bcr_stage_model.sv
`timescale 1ns/100ps
// ****************
// power stage side: external enable pin
// ****************
module bcr_stage_model
(
   // clock
   input wire logic clock,
   // pin request from the bench
   input wire logic pin_req,
   // pin seen by the block
   output logic ext_enable_pin
);
   // the pin moves off the clock edge, as a real board pin would
   // one driver only; the block holds its synchroniser in reset until the pin is known
   always @(negedge clock) ext_enable_pin <= pin_req;
endmodule

// >>> dv/bcr_regs_bench.sv
`timescale 1ns/100ps
module bcr_regs_bench;
   import bcr_pkg::*;
   logic clock, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, pin_req = 0, ext_enable_pin;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, k;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   bcr_reg0_t reg0_ctrl;
   bcr_reg1_t reg1_ctrl;
   int mem [3:6];
   int pin, fails, checks_done, cyc, c;
   logic [7:0] vt [10] = '{8'h00, 8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF, 8'h5A, 8'hC3};
   bcr_regs #(.ADDR_W(8)) bcr_regs_inst (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_enable_pin, .reg0_ctrl,
      .reg1_ctrl);
   bcr_stage_model bcr_stage_model_inst (.clock, .pin_req, .ext_enable_pin);
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // ****************
   // reference model
   // ****************
   function automatic bit mapped(int a);
      return a % 4 == 0 && a / 4 >= 3 && a / 4 <= 6;
   endfunction
   function automatic int mv(int v);
      if (v < 'h14) return 0;
      if (v < 'h18) return 700 + 10 * (v - 'h14);
      if (v < 'h9E) return 735 + 5 * (v - 'h18);
      return 1420 + 20 * (v - 'h9E);
   endfunction
   function automatic logic [34:0] exp_ctrl();
      logic on;
      on = mem[4][0] && (!mem[4][1] || pin != 0);
      return {mem[3][5:0], mem[6][7:0], 12'(mv(mem[6])), mem[5][5:0], mem[4][3],
         mem[4][2] && !on, on};
   endfunction
   // reserved codes leave the field as it was; out-of-range voltage is dropped whole
   function automatic void mwrite(int a, logic [7:0] d, logic s);
      int i;
      i = a / 4;
      if (!mapped(a) || !s) return;
      if (i == 4) mem[4] = d & 'hF;
      else if (i != 6) mem[i] = {(d[5:3] <= 3'h5) ? d[5:3] : 3'(mem[i] >> 3),
         (d[2:0] >= 3'h2) ? d[2:0] : 3'(mem[i])};
      else if (d >= 8'h14) mem[6] = d;
   endfunction
   // ****************
   // compare and bus tasks
   // ****************
   task automatic chk_bus(logic [33:0] got, logic [33:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t bus got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(logic [34:0] got, logic [34:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t ctrl got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d, logic s);
      mwrite(a, d, s);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= {3'($urandom), s};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each write channel is released on its own ready
      do
      begin
         @(posedge clock);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk_bus({s_axi_bresp, 32'h0}, {mapped(a) ? 2'h0 : 2'h2, 32'h0});
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clock);
      while (s_axi_arready !== 1'b1) @(posedge clock);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      s_axi_rready <= 1'b0;
      chk_bus({s_axi_rresp, s_axi_rdata}, mapped(a) ? {2'h0, 32'(mem[a / 4])} : {2'h2, 32'h0});
   endtask
   task automatic close_out();
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard sized well above the several hundred cycles the run needs
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         close_out();
      end
   end
   // ****************
   // scenarios
   // ****************
   initial
   begin
      void'($urandom(32'hEB50));
      mem[3] = 'h2C;
      mem[4] = 'h0F;
      mem[5] = 'h2C;
      mem[6] = 'h80;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (8) @(posedge clock);
      chk_out({reg0_ctrl, reg1_ctrl}, exp_ctrl());
      for (c = 3; c <= 6; c++) rd(8'(c * 4));
      wr(8'h10, 8'h01, 1'b1);
      for (c = 0; c < 16; c++)
      begin
         k = 8'($urandom);
         k[5:3] = c[2:0];
         k[2:0] = 3'(c * 5);
         wr(c[3] ? 8'h14 : 8'h0C, k, 1'b1);
         repeat (3) @(posedge clock);
         chk_out({reg0_ctrl, reg1_ctrl}, exp_ctrl());
      end
      for (c = 0; c < 10; c++)
      begin
         wr(8'h18, vt[c], 1'b1);
         repeat (3) @(posedge clock);
         chk_out({reg0_ctrl, reg1_ctrl}, exp_ctrl());
      end
      for (c = 0; c < 32; c++)
      begin
         pin_req <= c[4];
         pin = c / 16;
         wr(8'h10, {4'($urandom), c[3:0]}, 1'b1);
         repeat (8) @(posedge clock);
         chk_out({reg0_ctrl, reg1_ctrl}, exp_ctrl());
      end
      wr(8'h1C, 8'h55, 1'b1);
      wr(8'h0D, 8'h00, 1'b1);
      wr(8'h18, 8'h33, 1'b0);
      rd(8'h1C);
      rd(8'h0E);
      rd(8'h18);
      close_out();
   end
endmodule
